// file: rtl/mls_pkg.sv
// Package for the move/literal/sleep execute block
// Assumes a single core clock and decoded opcodes from fetch
package mls_pkg;
  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int          MLS_DATA_W   = 8;          // Data path width
  localparam int          MLS_ADDR_W   = 5;          // File address width, 0 to 31
  localparam int          MLS_PC_W     = 11;         // Program counter width
  localparam logic [7:0]  MLS_ACC_RST  = 8'h00;      // Accumulator after reset
  localparam logic [7:0]  MLS_OPT_RST  = 8'hFF;      // Timer config after reset
  localparam logic [7:0]  MLS_WDOG_CLR = 8'h00;      // Watchdog value on sleep
  localparam logic [7:0]  MLS_PRE_CLR  = 8'h00;      // Prescaler value on sleep
  localparam logic [10:0] MLS_PC_RST   = 11'h000;    // Program counter after reset
  localparam logic [10:0] MLS_PC_STEP  = 11'h001;    // Sequential advance

  // ****************************************
  // Operation codes from the fetch stage
  // ****************************************
  typedef enum logic [2:0] {
    OP_IDLE        = 3'b000,  // idle_op
    OP_OR_ACC_FILE = 3'b001,  // or_acc_into_file
    OP_COPY_ACC    = 3'b010,  // copy_acc_to_file
    OP_MOVE_FILE   = 3'b011,  // move_file
    OP_LOAD_LIT    = 3'b100,  // load_literal_acc
    OP_LOAD_OPT    = 3'b101,  // timer configuration load
    OP_RET_LIT     = 3'b110,  // return_with_literal
    OP_SLEEP       = 3'b111   // sleep entry
  } mls_op_t;

  // Execute state
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,  // Executing one op per cycle
    ST_FLUSH = 2'b01,  // Second cycle of a return
    ST_SLEEP = 2'b10   // Halted, oscillator stopped
  } mls_state_t;

  // Decoded instruction from fetch
  typedef struct packed {
    logic                  valid;  // Instruction present
    mls_op_t               op;     // Operation
    logic [4:0]            addr;   // File address
    logic                  dest;   // 0 accumulator, 1 file
    logic [7:0]            lit;    // Immediate
  } mls_instr_t;

  // File write request
  typedef struct packed {
    logic                  we;     // Write strobe
    logic [4:0]            addr;   // File address
    logic [7:0]            data;   // Write data
  } mls_fwr_t;
endpackage

// file: rtl/mls_zero_det.sv
// Zero detector for an 8-bit result
// Pure combinational leaf used by the execute block
`timescale 1ns/1ps
`default_nettype none
module mls_zero_det
  import mls_pkg::*;
#(
  parameter int WIDTH = MLS_DATA_W  // Result width
)
(
  input  wire logic [WIDTH-1:0] value_i,  // Result to test
  output logic                  zero_o    // High when all bits zero
);
  // Reduction NOR of the result
  assign zero_o = ~(|value_i);
endmodule
`default_nettype wire

// file: rtl/mls_exec.sv
// Execute stage for OR, moves, literal load, idle, timer config load,
// return with literal and sleep entry.
// Assumes fetch presents one decoded instruction per cycle and that the
// register file returns the addressed byte combinationally on file_rdata_i.
`timescale 1ns/1ps
`default_nettype none
module mls_exec
  import mls_pkg::*;
(
  input  wire logic        clk_i,            // Core clock, 100 MHz
  input  wire logic        resetn_i,         // Async reset, active low
  input  wire mls_instr_t  instr_i,          // Decoded instruction
  input  wire logic [7:0]  file_rdata_i,     // Addressed file contents
  input  wire logic [10:0] stack_top_i,      // Return address
  input  wire logic        wake_i,           // Wake request, leaves sleep
  output mls_fwr_t         file_wr_o,        // File write request
  output logic [4:0]       file_raddr_o,     // File read address
  output logic [7:0]       acc_o,            // Accumulator
  output logic [7:0]       timer_cfg_o,      // Timer configuration
  output logic             zero_flag_o,      // Zero flag
  output logic             timeout_flag_n_o, // Timeout status, active low
  output logic             powerdown_flag_n_o, // Powerdown status, active low
  output logic [7:0]       watchdog_counter_o, // Watchdog count
  output logic [7:0]       prescaler_o,      // Watchdog prescaler
  output logic [10:0]      pc_o,             // Program counter
  output logic             stack_pop_o,      // Pop pulse on return
  output logic             discard_o,        // Fetched instruction dropped
  output logic             osc_stop_o        // Oscillator stopped
);
  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_reg;  // First stage
  logic rst_n;         // Released reset

  // Release reset through two flops
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Wake pin synchroniser
  logic wake_meta_reg;  // First stage
  logic wake_sync_reg;  // Second stage

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end
    else
    begin
      wake_meta_reg <= wake_i;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  mls_state_t state_reg;   // Execute state
  logic       exec;        // Instruction executes this cycle
  logic [7:0] or_res;      // OR result
  logic [7:0] zsrc;        // Value tested for zero
  logic       zero_det;    // Zero of zsrc

  assign exec   = instr_i.valid && (state_reg == ST_RUN);
  assign or_res = acc_o | file_rdata_i;
  assign zsrc   = (instr_i.op == OP_OR_ACC_FILE) ? or_res : file_rdata_i;

  mls_zero_det #(.WIDTH(MLS_DATA_W)) u_zero
  (
    .value_i (zsrc),
    .zero_o  (zero_det)
  );

  // ****************************************
  // State machine
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= ST_RUN;
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          if (exec && instr_i.op == OP_RET_LIT)
            state_reg <= ST_FLUSH;
          else if (exec && instr_i.op == OP_SLEEP)
            state_reg <= ST_SLEEP;
        end
        ST_FLUSH: state_reg <= ST_RUN;
        ST_SLEEP: if (wake_sync_reg) state_reg <= ST_RUN;  // Wake resumes execution
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // Oscillator stop mirrors sleep state
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      osc_stop_o <= 1'b0;
    else if (exec && instr_i.op == OP_SLEEP)
      osc_stop_o <= 1'b1;
    else if (state_reg == ST_SLEEP && wake_sync_reg)
      osc_stop_o <= 1'b0;
  end

  // ****************************************
  // Accumulator and timer configuration
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      acc_o <= MLS_ACC_RST;
    else if (exec)
    begin
      case (instr_i.op)
        OP_OR_ACC_FILE: if (!instr_i.dest) acc_o <= or_res;
        OP_MOVE_FILE:   if (!instr_i.dest) acc_o <= file_rdata_i;
        OP_LOAD_LIT:    acc_o <= instr_i.lit;
        OP_RET_LIT:     acc_o <= instr_i.lit;
        default:        acc_o <= acc_o;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      timer_cfg_o <= MLS_OPT_RST;
    else if (exec && instr_i.op == OP_LOAD_OPT)
      timer_cfg_o <= acc_o;
  end

  // ****************************************
  // Zero flag, touched only by OR and move
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      zero_flag_o <= 1'b0;
    else if (exec && (instr_i.op == OP_OR_ACC_FILE || instr_i.op == OP_MOVE_FILE))
      zero_flag_o <= zero_det;
  end

  // ****************************************
  // File write port
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      file_wr_o <= '0;
    else
    begin
      file_wr_o.addr <= instr_i.addr;
      file_wr_o.we   <= 1'b0;
      file_wr_o.data <= acc_o;
      if (exec)
      begin
        case (instr_i.op)
          OP_OR_ACC_FILE:
          begin
            file_wr_o.we   <= instr_i.dest;
            file_wr_o.data <= or_res;
          end
          OP_COPY_ACC: file_wr_o.we <= 1'b1;  // Data defaults to the accumulator
          OP_MOVE_FILE:
          begin
            file_wr_o.we   <= instr_i.dest;
            file_wr_o.data <= file_rdata_i;
          end
          default: file_wr_o.we <= 1'b0;
        endcase
      end
    end
  end

  // Read address follows the fetch operand
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      file_raddr_o <= '0;
    else
      file_raddr_o <= instr_i.addr;
  end
  // ****************************************
  // Watchdog and status bits
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      watchdog_counter_o <= MLS_WDOG_CLR;
      prescaler_o        <= MLS_PRE_CLR;
      timeout_flag_n_o   <= 1'b1;
      powerdown_flag_n_o <= 1'b1;
    end
    else if (exec && instr_i.op == OP_SLEEP)
    begin
      watchdog_counter_o <= MLS_WDOG_CLR;
      prescaler_o        <= MLS_PRE_CLR;
      timeout_flag_n_o   <= 1'b1;
      powerdown_flag_n_o <= 1'b0;
    end
    else if (state_reg != ST_SLEEP)
    begin
      prescaler_o <= prescaler_o + 8'h01;
      if (prescaler_o == 8'hFF)
        watchdog_counter_o <= watchdog_counter_o + 8'h01;
    end
  end

  // ****************************************
  // Program counter, pop and discard
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_o        <= MLS_PC_RST;
      stack_pop_o <= 1'b0;
      discard_o   <= 1'b0;
    end
    else
    begin
      stack_pop_o <= exec && instr_i.op == OP_RET_LIT;
      discard_o   <= exec && instr_i.op == OP_RET_LIT;
      if (exec && instr_i.op == OP_RET_LIT)
        pc_o <= stack_top_i;
      else if (exec && instr_i.op != OP_SLEEP)
        pc_o <= pc_o + MLS_PC_STEP;
      else if (state_reg == ST_SLEEP && wake_sync_reg)
        pc_o <= pc_o + MLS_PC_STEP;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_ret;
    exec && instr_i.op == OP_RET_LIT;
  endsequence
  sequence s_sleep;
    exec && instr_i.op == OP_SLEEP;
  endsequence
  chk_ret_two_cycle: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_ret |=> (state_reg == ST_FLUSH && discard_o) ##1 state_reg == ST_RUN) else $error("return not two cycles");
  chk_ret_pc_load: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_ret |=> pc_o == $past(stack_top_i) && acc_o == $past(instr_i.lit)) else $error("return load wrong");
  chk_sleep_status: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_sleep |=> timeout_flag_n_o && !powerdown_flag_n_o) else $error("sleep status wrong");
  chk_sleep_wdog_clr: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_sleep |=> watchdog_counter_o == 8'h00 && prescaler_o == 8'h00) else $error("watchdog not cleared");
  chk_sleep_halt: assert property (@(posedge clk_i) disable iff (!rst_n)
    state_reg == ST_SLEEP && !wake_sync_reg |=> $stable(pc_o) && osc_stop_o) else $error("sleep not halted");
  chk_or_acc_dest: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && instr_i.op == OP_OR_ACC_FILE && !instr_i.dest
      |=> acc_o == $past(or_res) && !file_wr_o.we) else $error("or destination wrong");
  chk_copy_acc_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && instr_i.op == OP_COPY_ACC |=> file_wr_o.we && $stable(zero_flag_o)) else $error("copy wrong");
  chk_move_test_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && instr_i.op == OP_MOVE_FILE && instr_i.dest
      |=> file_wr_o.data == $past(file_rdata_i) && zero_flag_o == ($past(file_rdata_i) == 8'h00))
    else $error("move test wrong");
  chk_seq_advance: assert property (@(posedge clk_i) disable iff (!rst_n)
    exec && instr_i.op == OP_IDLE
      |=> pc_o == $past(pc_o) + 11'h001 && $stable(acc_o)) else $error("idle advance wrong");
endmodule
`default_nettype wire

// file: testbench/mls_far_model.sv
// Model of the register file and return stack facing the execute block
// Assumes writes land on the edge after the write pulse
`timescale 1ns/1ps
`default_nettype none
module mls_far_model
  import mls_pkg::*;
#(
  parameter logic [10:0] RET_ADDR = 11'h2A5  // Return address offered
)
(
  input  wire logic       clk_i,       // Core clock
  input  wire mls_instr_t instr_i,     // Read address source
  input  wire mls_fwr_t   file_wr_i,   // Write request
  output logic [7:0]      rdata_o,     // Addressed contents
  output logic [10:0]     stack_top_o  // Return address
);
  // ****************************************
  // File storage, seeded with a known pattern
  // ****************************************
  logic [7:0] mem [32];  // File registers 0 to 31
  initial
  begin
    for (int i = 0; i < 32; i++)
      mem[i] = 8'(i * 9);
  end
  // Write back the result chosen by the destination bit
  always @(posedge clk_i)
  begin
    if (file_wr_i.we)
      mem[file_wr_i.addr] <= file_wr_i.data;
  end
  assign rdata_o     = mem[instr_i.addr];  // Combinational read
  assign stack_top_o = RET_ADDR;           // Fixed return address
endmodule
`default_nettype wire

// file: testbench/test_move_or_literal_sleep_exec.sv
// Self-checking bench for the execute block
// Assumes the far-side model above and one op per two cycles
`timescale 1ns/1ps
`default_nettype none
module test_move_or_literal_sleep_exec
  import mls_pkg::*;
;
  localparam logic [10:0] RET = 11'h2A5;  // Return address used
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wake_i = 1'b0;
  mls_instr_t instr = '0;
  logic [7:0] rdata, acc_o, cfg_o, wdog_o, pre_o;
  logic [10:0] stk, pc_o;
  logic [4:0] raddr;
  mls_fwr_t fwr;
  logic z_o, tmo_n, pwrdn_n, pop_o, disc_o, osc_o;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] sh [32];
  logic [7:0] e_acc = 8'h00;
  logic [7:0] e_cfg = 8'hFF;
  logic e_z = 1'b0;
  logic [10:0] e_pc = 11'h000;
  always #5 clk_i = ~clk_i;
  mls_exec dut (.clk_i(clk_i), .resetn_i(resetn_i), .instr_i(instr), .file_rdata_i(rdata),
    .stack_top_i(stk), .wake_i(wake_i), .file_wr_o(fwr), .file_raddr_o(raddr), .acc_o(acc_o),
    .timer_cfg_o(cfg_o), .zero_flag_o(z_o), .timeout_flag_n_o(tmo_n), .powerdown_flag_n_o(pwrdn_n),
    .watchdog_counter_o(wdog_o), .prescaler_o(pre_o), .pc_o(pc_o), .stack_pop_o(pop_o),
    .discard_o(disc_o), .osc_stop_o(osc_o));
  mls_far_model #(.RET_ADDR(RET)) far (.clk_i(clk_i), .instr_i(instr), .file_wr_i(fwr),
    .rdata_o(rdata), .stack_top_o(stk));
  // ****************************************
  // Compare, report and hang guard
  // ****************************************
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_fail++;
      results();
    end
  end
  // Present one instruction, then what follows it on the taking edge
  task automatic issue(input mls_instr_t ins, input mls_instr_t nxt);
    @(posedge clk_i);
    instr <= ins;
    @(posedge clk_i);
    instr <= nxt;
    #1;
  endtask
  // Single-cycle op with expected results worked out here
  task automatic step(input mls_op_t op, input logic [4:0] a, input logic d, input logic [7:0] k);
    logic [7:0] r;
    logic wr;
    logic zop;
    zop = (op == OP_OR_ACC_FILE) || (op == OP_MOVE_FILE);
    r = (op == OP_OR_ACC_FILE) ? (e_acc | sh[a]) : (op == OP_COPY_ACC) ? e_acc : sh[a];
    wr = (op == OP_COPY_ACC) || (zop && d);
    if (zop)
    begin
      e_z = (r == 8'h00);
      if (!d)
        e_acc = r;
    end
    if (op == OP_LOAD_LIT)
      e_acc = k;
    if (op == OP_LOAD_OPT)
      e_cfg = e_acc;
    if (wr)
      sh[a] = r;
    e_pc = e_pc + 11'h001;
    issue('{1'b1, op, a, d, k}, '0);
    chk(acc_o, e_acc);
    chk(z_o, e_z);
    chk(cfg_o, e_cfg);
    chk(pc_o, e_pc);
    chk(fwr.we, wr);
    chk(raddr, a);
    if (wr)
    begin
      chk(fwr.addr, a);
      chk(fwr.data, r);
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    for (int i = 0; i < 32; i++)
      sh[i] = 8'(i * 9);
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk(cfg_o, 8'hFF);
    chk(pwrdn_n, 1'b1);
    step(OP_LOAD_LIT, 5'h00, 1'b0, 8'h00);
    step(OP_OR_ACC_FILE, 5'h00, 1'b0, 8'h00);
    step(OP_LOAD_LIT, 5'h00, 1'b0, 8'hFF);
    step(OP_COPY_ACC, 5'h1F, 1'b0, 8'h00);
    step(OP_MOVE_FILE, 5'h1F, 1'b0, 8'h00);
    step(OP_OR_ACC_FILE, 5'h05, 1'b1, 8'h00);
    step(OP_LOAD_LIT, 5'h00, 1'b0, 8'h5A);
    step(OP_LOAD_OPT, 5'h00, 1'b0, 8'h00);
    step(OP_MOVE_FILE, 5'h00, 1'b1, 8'h00);
    step(OP_MOVE_FILE, 5'h05, 1'b1, 8'h00);
    step(OP_IDLE, 5'h03, 1'b1, 8'h77);
    // Return with a following instruction held through the flush cycle
    issue('{1'b1, OP_RET_LIT, 5'h00, 1'b0, 8'h3C}, '{1'b1, OP_LOAD_LIT, 5'h00, 1'b0, 8'h11});
    chk(acc_o, 8'h3C);
    chk(pc_o, RET);
    chk(pop_o, 1'b1);
    chk(disc_o, 1'b1);
    chk(z_o, e_z);
    @(posedge clk_i);
    instr <= '0;
    #1;
    chk(acc_o, 8'h3C);
    chk(pc_o, RET);
    chk(pop_o, 1'b0);
    e_acc = 8'h3C;
    e_pc = RET;
    step(OP_LOAD_LIT, 5'h00, 1'b0, 8'hC3);
    // Idle until the prescaler has wrapped, so sleep has a watchdog count to clear
    repeat (300) @(posedge clk_i);
    // Sleep with an instruction pending that must not run
    issue('{1'b1, OP_SLEEP, 5'h00, 1'b0, 8'h00}, '{1'b1, OP_LOAD_LIT, 5'h00, 1'b0, 8'h99});
    chk(wdog_o, 8'h00);
    chk(pre_o, 8'h00);
    chk(tmo_n, 1'b1);
    chk(pwrdn_n, 1'b0);
    chk(osc_o, 1'b1);
    repeat (5) @(posedge clk_i);
    #1;
    chk(acc_o, e_acc);
    chk(pc_o, e_pc);
    chk(pre_o, 8'h00);
    chk(osc_o, 1'b1);
    // Wake passes two synchroniser edges and resumes on the third
    @(posedge clk_i);
    instr <= '0;
    wake_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk(osc_o, 1'b1);
    @(posedge clk_i);
    wake_i <= 1'b0;
    #1;
    chk(osc_o, 1'b0);
    chk(pc_o, e_pc + 11'h001);
    results();
  end
endmodule
`default_nettype wire
